// ---- hw/mds_decoder.sv ----
// memory-space decoder: routes operand accesses to ram, sfr, extended_internal_ram or flash
// Function
// - 256-byte general-purpose ram at 0x00-0xFF holds the register banks.
// - addresses up to 0x7F reach general ram in direct and indirect mode.
// - indirect access at 0x80 and above reaches upper ram, never an sfr.
// - direct access at 0x80-0xFF goes to the special function registers, except 0xAF, the config register held in the decoder.
// - bit addresses 0x00-0x7F map onto ram bytes 0x20-0x2F, ascending.
// - bit-addressable sfrs allow single-bit reads and writes.
// - boolean and branch operations reach single bits without masking.
// - 256-byte extended ram at 0x0000-0x00FF, reached only by extended moves and stack accesses.
// - writing 01 to config bits 1:0 at 0xAF enables extended ram.
// - no external memory cycles; extended accesses stay on chip.
// - code and constants live in 16 kB flash, read code-indirect.
// - immediate operands come from flash; 2 cycles, or 3 for pointer load.
// - register move with accumulator takes one cycle, the fastest access.
// - register-indirect uses register contents as ram address, 2 cycles.
// - extended direct uses the data pointer as address, 4 cycles.
// - extended indirect uses a working register as address, 4 cycles.
// - both extended modes reach all 256 extended ram bytes.
// - code reads add accumulator to pointer or pc, 4 cycles; jump 3.
// - two bank-select bits of the status word at 0xD0 pick the bank.
// - stack lives in extended ram, addressed by the stack pointer.
`timescale 1ns/100ps
`default_nettype none
module mds_decoder
  import mds_pkg::*;
(
  input  wire logic               clk,          // 20 MHz core clock
  input  wire logic               reset_n,      // async reset, active low
  input  wire logic               reqValid,     // request present
  input  wire mds_req_t           req,          // request fields
  output logic                    reqReady,     // block idle, takes request
  output logic                    respValid,    // one-cycle completion pulse
  output mds_resp_t               resp,         // read result
  output mds_space_t              routeSpace,   // space of current access
  output logic                    sfrStrobe,    // sfr access strobe
  output logic                    sfrWrite,     // sfr write qualifier
  output logic      [7:0]         sfrAddr,      // sfr byte address
  output logic      [7:0]         sfrWdata,     // sfr write data
  input  wire logic [7:0]         sfrRdata,     // sfr data, cycle after strobe
  output logic                    codeRead,     // flash read strobe
  output logic      [CODE_AW-1:0] codeAddr,     // flash byte address
  input  wire logic [7:0]         codeData,     // flash data, cycle after read
  output logic      [1:0]         bankSelect,   // active register bank
  output logic                    xramEnabled   // extended ram switched on
);

  // =====================================================================
  // state and held request
  typedef enum logic {ST_IDLE, ST_BUSY} mds_state_t;

  mds_state_t state;
  mds_req_t   held;
  logic [2:0] count;
  logic [7:0] dataByte;
  logic [7:0] hiByte;
  logic [7:0] memoryConfiguration;
  logic [15:0] jumpTarget;

  // =====================================================================
  // request decode
  logic        busy;
  logic        accept;
  logic        first;
  mds_req_t    cur;
  mds_space_t  space;
  logic [7:0]  memAddr;
  logic [7:0]  bitByte;
  logic [2:0]  bitIdx;
  logic        lowHalf;
  logic [15:0] codeSum;
  logic [15:0] immAddr;
  logic        isImm;
  logic        bitWr;
  logic [2:0]  curCycles;
  logic        done;

  assign busy      = (state == ST_BUSY);
  assign accept    = reqValid && !busy;
  assign first     = busy && (count == 3'h1);
  assign cur       = busy ? held : req;
  assign lowHalf   = (cur.addr[7:0] < SFR_SPLIT);
  assign bitIdx    = cur.addr[2:0];
  assign curCycles = mdsCycles(held.mode);
  assign done      = busy && (count == curCycles);

  // bit area: low half in ram 0x20..0x2F, high half in sfr byte
  assign bitByte = cur.addr[7] ? {cur.addr[7:3], 3'h0}
                               : {BIT_RAM_BASE, cur.addr[6:3]};

  always_comb begin
    space   = SPC_NONE;
    memAddr = cur.addr[7:0];
    case (cur.mode)
      MD_IMM_ACC, MD_IMM_DATA_POINTER, MD_CODE_DATA_POINTER, MD_CODE_PC: begin
        space = SPC_CODE;
      end
      MD_REG: begin
        space   = SPC_GPRAM;
        memAddr = {3'h0, bankSelect, cur.regIndex};
      end
      MD_DIRECT: begin
        if (lowHalf) begin
          space = SPC_GPRAM;
        end else if (cur.addr[7:0] == CFG_ADDR) begin
          space = SPC_CFG;
        end else begin
          space = SPC_SFR;
        end
      end
      MD_INDIRECT: begin
        space = SPC_GPRAM;
      end
      MD_EXT_DATA_POINTER, MD_EXT_REG, MD_STACK: begin
        space = SPC_EXTENDED_INTERNAL_RAM;
      end
      MD_BIT: begin
        memAddr = bitByte;
        space   = cur.addr[7] ? SPC_SFR : SPC_GPRAM;
      end
      default: begin
        space = SPC_NONE;
      end
    endcase
  end

  assign routeSpace = space;

  // =====================================================================
  // memories and read selection
  logic       gpRe;
  logic       gpWe;
  logic [7:0] gpRdata;
  logic       xRe;
  logic       xWe;
  logic [7:0] xRdata;
  logic [7:0] rdByte;
  logic [7:0] bitMask;
  logic [7:0] patched;
  logic [7:0] wrByte;
  logic [7:0] byteOut;

  assign xramEnabled = (memoryConfiguration[1:0] == CFG_EXTENDED_INTERNAL_RAM_ON);

  // single-bit write is a read-modify-write finishing in the second cycle
  assign bitWr   = first && (held.mode == MD_BIT) && held.write;
  assign bitMask = 8'h01 << bitIdx;
  assign patched = held.bitValue ? (rdByte | bitMask)
                                 : (rdByte & ~bitMask);
  assign wrByte  = bitWr ? patched : cur.wdata;

  assign gpRe = accept && (space == SPC_GPRAM);
  assign gpWe = (gpRe && req.write && (req.mode != MD_BIT))
              || (bitWr && (space == SPC_GPRAM));

  // extended ram only answers when enabled; nothing leaves the chip
  assign xRe = accept && (space == SPC_EXTENDED_INTERNAL_RAM) && xramEnabled;
  assign xWe = xRe && req.write;

  mds_ram u_gpRam (
    .clk     (clk),
    .reset_n (reset_n),
    .re      (gpRe),
    .we      (gpWe),
    .addr    (memAddr),
    .wdata   (wrByte),
    .rdata   (gpRdata)
  );

  // low pointer byte only; stack pointer arrives in addr
  mds_ram u_extRam (
    .clk     (clk),
    .reset_n (reset_n),
    .re      (xRe),
    .we      (xWe),
    .addr    (cur.addr[7:0]),
    .wdata   (wrByte),
    .rdata   (xRdata)
  );

  always_comb begin
    case (space)
      SPC_GPRAM: rdByte = gpRdata;
      SPC_EXTENDED_INTERNAL_RAM:  rdByte = xramEnabled ? xRdata : 8'h00;
      SPC_SFR:   rdByte = sfrRdata;
      SPC_CODE:  rdByte = codeData;
      SPC_CFG:   rdByte = memoryConfiguration;
      default:   rdByte = 8'h00;
    endcase
  end

  // =====================================================================
  // sfr and flash ports
  assign sfrStrobe = (accept && (space == SPC_SFR))
                   || (bitWr && (space == SPC_SFR));
  assign sfrWrite  = (accept && (space == SPC_SFR) && req.write
                      && (req.mode != MD_BIT))
                   || (bitWr && (space == SPC_SFR));
  assign sfrAddr   = memAddr;
  assign sfrWdata  = wrByte;

  assign isImm   = (cur.mode == MD_IMM_ACC) || (cur.mode == MD_IMM_DATA_POINTER);
  assign codeSum = cur.addr + {8'h00, cur.acc};
  assign immAddr = first ? (cur.addr + 16'h0001) : cur.addr;

  assign codeRead = (accept && (space == SPC_CODE))
                  || (first && (held.mode == MD_IMM_DATA_POINTER));
  assign codeAddr = isImm ? immAddr[CODE_AW-1:0]
                          : codeSum[CODE_AW-1:0];

  // =====================================================================
  // sequencing
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= ST_IDLE;
    end else if (accept) begin
      state <= ST_BUSY;
    end else if (done) begin
      state <= ST_IDLE;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      count <= 3'h0;
    end else if (accept) begin
      count <= 3'h1;
    end else if (busy) begin
      count <= count + 3'h1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      held <= '0;
    end else if (accept) begin
      held <= req;
    end
  end

  // =====================================================================
  // captured data
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dataByte <= 8'h00;
    end else if (first || (busy && (count == 3'h2) && (held.mode == MD_IMM_DATA_POINTER))) begin
      dataByte <= rdByte;
    end
  end

  // pointer literal arrives high byte first
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hiByte <= 8'h00;
    end else if (first && (held.mode == MD_IMM_DATA_POINTER)) begin
      hiByte <= codeData;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      jumpTarget <= 16'h0000;
    end else if (accept && (req.mode == MD_JUMP)) begin
      jumpTarget <= codeSum;
    end
  end

  // =====================================================================
  // configuration and bank shadow
  logic cfgWr;
  logic pswWr;

  assign cfgWr = accept && (space == SPC_CFG) && req.write;
  assign pswWr = accept && (req.mode == MD_DIRECT) && req.write
               && (req.addr[7:0] == PSW_ADDR);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      memoryConfiguration <= CFG_RESET;
    end else if (cfgWr) begin
      memoryConfiguration <= req.wdata;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bankSelect <= BANK_RESET;
    end else if (pswWr) begin
      bankSelect <= req.wdata[PSW_BANK_LSB+1:PSW_BANK_LSB];
    end else if (bitWr && (held.addr[7:0] == PSW_BIT_BANK_LO)) begin
      bankSelect[0] <= held.bitValue;
    end else if (bitWr && (held.addr[7:0] == PSW_BIT_BANK_HI)) begin
      bankSelect[1] <= held.bitValue;
    end
  end

  // =====================================================================
  // response
  assign reqReady  = !busy;
  assign respValid = done;
  assign byteOut   = (count == 3'h1) ? rdByte : dataByte;

  always_comb begin
    case (held.mode)
      MD_JUMP:     resp.data = jumpTarget;
      MD_IMM_DATA_POINTER: resp.data = {hiByte, dataByte};
      default:     resp.data = {8'h00, byteOut};
    endcase
    resp.bitValue = byteOut[held.addr[2:0]];
  end

  // =====================================================================
  // assertions
  a_low_direct_ram: assert property (@(posedge clk) disable iff (!reset_n)
    accept && (req.mode == MD_DIRECT) && (req.addr[7:0] < SFR_SPLIT)
    |-> gpRe && !sfrStrobe)
    else $error("low direct access not routed to ram");

  a_indirect_upper: assert property (@(posedge clk) disable iff (!reset_n)
    accept && (req.mode == MD_INDIRECT)
    |-> gpRe && !sfrStrobe && (memAddr == req.addr[7:0]))
    else $error("indirect access reached sfr space");

  a_direct_sfr_route: assert property (@(posedge clk) disable iff (!reset_n)
    accept && (req.mode == MD_DIRECT) && req.addr[7] && (req.addr[7:0] != CFG_ADDR)
    |-> sfrStrobe && !gpRe && (sfrAddr == req.addr[7:0]))
    else $error("direct high access not routed to sfr");

  a_bit_byte_map: assert property (@(posedge clk) disable iff (!reset_n)
    accept && (req.mode == MD_BIT) && !req.addr[7]
    |-> gpRe && (memAddr == {BIT_RAM_BASE, req.addr[6:3]}))
    else $error("bit address mapped to wrong ram byte");

  a_bit_write_rmw: assert property (@(posedge clk) disable iff (!reset_n)
    accept && (req.mode == MD_BIT) && req.write && !req.addr[7]
    |-> !gpWe ##1 gpWe && (wrByte[req.addr[2:0]] == $past(req.bitValue)))
    else $error("bit write not patched in second cycle");

  a_extended_internal_ram_gate: assert property (@(posedge clk) disable iff (!reset_n)
    accept && (space == SPC_EXTENDED_INTERNAL_RAM) && !xramEnabled
    |-> !xRe && !xWe ##4 respValid && (resp.data == 16'h0000))
    else $error("disabled extended ram answered or was written");

  a_reg_one_cycle: assert property (@(posedge clk) disable iff (!reset_n)
    accept && (req.mode == MD_REG)
    |-> (memAddr == {3'h0, bankSelect, req.regIndex}) ##1 respValid)
    else $error("register access not one cycle in active bank");

  a_indirect_time: assert property (@(posedge clk) disable iff (!reset_n)
    accept && (req.mode == MD_INDIRECT) |=> !respValid ##1 respValid)
    else $error("indirect access not two cycles");

  a_ext_time: assert property (@(posedge clk) disable iff (!reset_n)
    accept && ((req.mode == MD_EXT_DATA_POINTER) || (req.mode == MD_EXT_REG))
    |=> !respValid [*3] ##1 respValid)
    else $error("extended access not four cycles");

  a_ext_low_byte: assert property (@(posedge clk) disable iff (!reset_n)
    accept && (req.mode == MD_EXT_DATA_POINTER) && xramEnabled
    |-> xRe && (cur.addr[7:0] == req.addr[7:0]))
    else $error("pointer access not on low byte");

  a_imm_data_pointer_time: assert property (@(posedge clk) disable iff (!reset_n)
    accept && (req.mode == MD_IMM_DATA_POINTER)
    |-> codeRead ##1 codeRead ##1 !respValid ##1 respValid)
    else $error("pointer literal load not three cycles");

  a_code_time: assert property (@(posedge clk) disable iff (!reset_n)
    accept && (req.mode == MD_CODE_DATA_POINTER)
    |-> (codeAddr == codeSum[CODE_AW-1:0]) ##4 respValid)
    else $error("code indirect read not four cycles");

  a_jump_time: assert property (@(posedge clk) disable iff (!reset_n)
    accept && (req.mode == MD_JUMP) |-> !codeRead ##3 respValid)
    else $error("indirect jump not three cycles");

  c_bit_sfr: cover property (@(posedge clk) disable iff (!reset_n)
    accept && (req.mode == MD_BIT) && req.addr[7] && req.write);
  c_stack_push: cover property (@(posedge clk) disable iff (!reset_n)
    accept && (req.mode == MD_STACK) && req.write && xramEnabled);
  c_bank_switch: cover property (@(posedge clk) disable iff (!reset_n)
    pswWr ##[1:20] accept && (req.mode == MD_REG));
  c_extended_internal_ram_enable: cover property (@(posedge clk) disable iff (!reset_n)
    cfgWr ##[1:20] xWe);

endmodule // mds_decoder
`default_nettype wire

// ---- hw/mds_pkg.sv ----
// package: types, addresses and cycle counts of the memory-space decoder
package mds_pkg;

  // =====================================================================
  // operand addressing modes issued by the execution unit
  typedef enum logic [3:0] {
    MD_IMM_ACC,
    MD_IMM_DATA_POINTER,
    MD_REG,
    MD_DIRECT,
    MD_INDIRECT,
    MD_EXT_DATA_POINTER,
    MD_EXT_REG,
    MD_STACK,
    MD_CODE_DATA_POINTER,
    MD_CODE_PC,
    MD_JUMP,
    MD_BIT
  } mds_mode_t;

  // memory space an access lands in
  typedef enum logic [2:0] {
    SPC_NONE,
    SPC_GPRAM,
    SPC_SFR,
    SPC_EXTENDED_INTERNAL_RAM,
    SPC_CODE,
    SPC_CFG
  } mds_space_t;

  // =====================================================================
  typedef struct packed {
    mds_mode_t   mode;
    logic        write;
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        bitValue;
    logic [7:0]  acc;
    logic [2:0]  regIndex;
  } mds_req_t;

  typedef struct packed {
    logic [15:0] data;
    logic        bitValue;
  } mds_resp_t;

  // =====================================================================
  localparam int         MEM_AW           = 8;
  localparam int         CODE_AW          = 14;
  localparam logic [7:0] SFR_SPLIT        = 8'h80;
  localparam logic [3:0] BIT_RAM_BASE     = 4'h2;
  localparam logic [7:0] CFG_ADDR         = 8'hAF;
  localparam logic [7:0] CFG_RESET        = 8'h00;
  localparam logic [1:0] CFG_EXTENDED_INTERNAL_RAM_ON      = 2'h1;
  localparam logic [7:0] PSW_ADDR         = 8'hD0;
  localparam int         PSW_BANK_LSB     = 3;
  localparam logic [7:0] PSW_BIT_BANK_LO  = 8'hD3;
  localparam logic [7:0] PSW_BIT_BANK_HI  = 8'hD4;
  localparam logic [1:0] BANK_RESET       = 2'h0;

  // =====================================================================
  localparam logic [2:0] CYC_IMM_ACC  = 3'h2;
  localparam logic [2:0] CYC_IMM_DATA_POINTER = 3'h3;
  localparam logic [2:0] CYC_REG      = 3'h1;
  localparam logic [2:0] CYC_DIRECT   = 3'h2;
  localparam logic [2:0] CYC_INDIRECT = 3'h2;
  localparam logic [2:0] CYC_EXT      = 3'h4;
  localparam logic [2:0] CYC_CODE     = 3'h4;
  localparam logic [2:0] CYC_JUMP     = 3'h3;
  localparam logic [2:0] CYC_BIT      = 3'h2;

  function automatic logic [2:0] mdsCycles(input mds_mode_t m);
    case (m)
      MD_IMM_ACC:                        mdsCycles = CYC_IMM_ACC;
      MD_IMM_DATA_POINTER:                       mdsCycles = CYC_IMM_DATA_POINTER;
      MD_REG:                            mdsCycles = CYC_REG;
      MD_DIRECT:                         mdsCycles = CYC_DIRECT;
      MD_INDIRECT:                       mdsCycles = CYC_INDIRECT;
      MD_EXT_DATA_POINTER, MD_EXT_REG, MD_STACK: mdsCycles = CYC_EXT;
      MD_CODE_DATA_POINTER, MD_CODE_PC:          mdsCycles = CYC_CODE;
      MD_JUMP:                           mdsCycles = CYC_JUMP;
      default:                           mdsCycles = CYC_BIT;
    endcase
  endfunction

endpackage

// ---- hw/mds_ram.sv ----
// 256x8 single-port ram with registered read data
`timescale 1ns/100ps
`default_nettype none
module mds_ram
  import mds_pkg::*;
(
  input  wire logic              clk,      // core clock
  input  wire logic              reset_n,  // async reset, active low
  input  wire logic              re,       // read enable
  input  wire logic              we,       // write enable
  input  wire logic [MEM_AW-1:0] addr,     // byte address
  input  wire logic [7:0]        wdata,    // write data
  output logic      [7:0]        rdata     // registered read data
);

  logic [7:0] mem [0:(1<<MEM_AW)-1];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
  end

  // read data holds until the next read
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata <= 8'h00;
    end else if (re) begin
      rdata <= mem[addr];
    end
  end

endmodule // mds_ram
`default_nettype wire

// ---- bench/mds_side_model.sv ----
// far-side model: special register file and flash behind the decoder
`timescale 1ns/100ps
`default_nettype none
module mds_side_model
  import mds_pkg::*;
(
  input  wire logic               clk,       // core clock
  input  wire logic               sfrStrobe, // register access
  input  wire logic               sfrWrite,  // register write
  input  wire logic [7:0]         sfrAddr,   // register address
  input  wire logic [7:0]         sfrWdata,  // register write data
  output logic      [7:0]         sfrRdata,  // register read data
  input  wire logic               codeRead,  // flash read
  input  wire logic [CODE_AW-1:0] codeAddr,  // flash address
  output logic      [7:0]         codeData   // flash data
);
  logic [7:0] sfrMem [256];
  logic [7:0] flashByte;
  initial begin
    for (int i = 0; i < 256; i++) begin
      sfrMem[i] = 8'h00;
    end
  end
  assign flashByte = codeAddr[7:0] ^ {2'h0, codeAddr[13:8]} ^ 8'hA5;
  // =====================================================================
  // answer the cycle after a strobe, show the inverse otherwise
  always @(posedge clk) begin
    sfrRdata <= sfrStrobe ? sfrMem[sfrAddr] : ~sfrMem[sfrAddr];
    if (sfrStrobe && sfrWrite) begin
      sfrMem[sfrAddr] <= sfrWdata;
    end
    codeData <= codeRead ? flashByte : ~flashByte;
  end
endmodule // mds_side_model
`default_nettype wire

// ---- bench/mds_decoder_tb.sv ----
// self-checking bench for the memory-space decoder
`timescale 1ns/100ps
`default_nettype none
module mds_decoder_tb
  import mds_pkg::*;
;
  typedef struct {
    logic [15:0] data;
    int          kind;
    int          at;
  } mds_exp_t;
  localparam logic [7:0] ADR [4] = '{8'h00, 8'h7F, 8'h80, 8'hFF};
  localparam logic [7:0] BITA [2] = '{8'h05, 8'h7F};
  localparam logic [7:0] BYTA [2] = '{8'h20, 8'h2F};
  logic               clk, reset_n, reqValid, reqReady, respValid;
  logic               sfrStrobe, sfrWrite, codeRead, xramEnabled;
  logic [7:0]         sfrAddr, sfrWdata, sfrRdata, codeData, v, w;
  logic [CODE_AW-1:0] codeAddr;
  logic [1:0]         bankSelect;
  logic [31:0]        rnd;
  mds_req_t           req;
  mds_resp_t          resp;
  mds_space_t         routeSpace;
  mds_exp_t           expQ [$];
  int                 failures, tests_run, cyc;

  mds_decoder mds_decoder_inst (.clk, .reset_n, .reqValid, .req, .reqReady, .respValid,
    .resp, .routeSpace, .sfrStrobe, .sfrWrite, .sfrAddr, .sfrWdata, .sfrRdata,
    .codeRead, .codeAddr, .codeData, .bankSelect, .xramEnabled);
  mds_side_model mds_side_model_inst (.clk, .sfrStrobe, .sfrWrite, .sfrAddr, .sfrWdata,
    .sfrRdata, .codeRead, .codeAddr, .codeData);

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;

  // =====================================================================
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [15:0] fb(input logic [15:0] a);
    return {8'h00, a[7:0] ^ {2'h0, a[13:8]} ^ 8'hA5};
  endfunction
  // space each mode and address must reach
  function automatic mds_space_t expSpace(input mds_mode_t m, input logic [15:0] a);
    case (m)
      MD_IMM_ACC, MD_IMM_DATA_POINTER, MD_CODE_DATA_POINTER, MD_CODE_PC: return SPC_CODE;
      MD_REG, MD_INDIRECT:                               return SPC_GPRAM;
      MD_EXT_DATA_POINTER, MD_EXT_REG, MD_STACK:                 return SPC_EXTENDED_INTERNAL_RAM;
      MD_DIRECT: return !a[7] ? SPC_GPRAM : ((a[7:0] == CFG_ADDR) ? SPC_CFG : SPC_SFR);
      MD_BIT:    return a[7] ? SPC_SFR : SPC_GPRAM;
      default:   return SPC_NONE;
    endcase
  endfunction
  task automatic complete_run();
    $display("failures=%0d tests_run=%0d", failures, tests_run);
    if (failures == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic checkVal(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic checkBit(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // kind: 0 latency only, 1 byte or word, 2 single bit
  task automatic doReq(input mds_mode_t m, input logic wr, input logic [15:0] a,
                       input logic [7:0] wd, input logic [15:0] ed, input int k, input int n);
    @(negedge clk);
    req = '{m, wr, a, wd, wd[0], wd, a[2:0]};
    reqValid = 1'b1;
    expQ.push_back('{ed, k, cyc + n});
    #1;
    checkBit(reqReady, 1'b1);
    checkVal(16'(routeSpace), 16'(expSpace(m, a)));
    @(negedge clk);
    reqValid = 1'b0;
    checkBit(reqReady, 1'b0);
    for (int i = 0; i < 12 && expQ.size() > 0; i++) begin
      @(negedge clk);
    end
    if (expQ.size() > 0) begin
      failures++;
      complete_run();
    end
  endtask

  // =====================================================================
  // monitor: oldest note against each completion
  always @(negedge clk) begin : mon
    mds_exp_t e;
    if (reset_n === 1'b1 && respValid === 1'b1) begin
      e = (expQ.size() > 0) ? expQ.pop_front() : '{16'hDEAD, 1, -1};
      checkVal(16'(cyc), 16'(e.at));
      if (e.kind == 1) checkVal(resp.data, e.data);
      if (e.kind == 2) checkBit(resp.bitValue, e.data[0]);
    end
  end

  initial begin
    reset_n = 1'b0;
    reqValid = 1'b0;
    req = '0;
    failures = 0;
    tests_run = 0;
    rnd = 32'hA32D;
    repeat (20) @(posedge clk);
    @(negedge clk);
    reset_n = 1'b1;
    checkVal(16'(bankSelect), 16'h0000);
    checkBit(xramEnabled, 1'b0);
    doReq(MD_DIRECT, 1'b0, 16'h00AF, 8'h00, 16'h0000, 1, 2);
    // ram and register space split at both boundaries
    foreach (ADR[i]) begin
      rnd = lfsr(rnd);
      v = rnd[7:0];
      w = rnd[15:8];
      doReq(MD_DIRECT, 1'b1, {8'h00, ADR[i]}, v, 16'h0000, 0, 2);
      doReq(MD_INDIRECT, 1'b1, {8'h00, ADR[i]}, w, 16'h0000, 0, 2);
      doReq(MD_DIRECT, 1'b0, {8'h00, ADR[i]}, 8'h00, {8'h00, ADR[i][7] ? v : w}, 1, 2);
      doReq(MD_INDIRECT, 1'b0, {8'h00, ADR[i]}, 8'h00, {8'h00, w}, 1, 2);
    end
    foreach (BITA[i]) begin
      doReq(MD_DIRECT, 1'b1, {8'h00, BYTA[i]}, 8'h00, 16'h0000, 0, 2);
      doReq(MD_BIT, 1'b1, {8'h00, BITA[i]}, 8'h01, 16'h0000, 0, 2);
      doReq(MD_DIRECT, 1'b0, {8'h00, BYTA[i]}, 8'h00, 16'(8'h01 << BITA[i][2:0]), 1, 2);
      doReq(MD_BIT, 1'b0, {8'h00, BITA[i]}, 8'h00, 16'h0001, 2, 2);
    end
    // bank select through a bit write and a byte write of the status word
    doReq(MD_BIT, 1'b1, {8'h00, PSW_BIT_BANK_LO}, 8'h01, 16'h0000, 0, 2);
    checkVal(16'(bankSelect), 16'h0001);
    doReq(MD_REG, 1'b1, 16'h0003, v, 16'h0000, 0, 1);
    doReq(MD_REG, 1'b0, 16'h0003, 8'h00, {8'h00, v}, 1, 1);
    doReq(MD_DIRECT, 1'b0, 16'h000B, 8'h00, {8'h00, v}, 1, 2);
    doReq(MD_DIRECT, 1'b1, {8'h00, PSW_ADDR}, 8'h10, 16'h0000, 0, 2);
    checkVal(16'(bankSelect), 16'h0002);
    doReq(MD_DIRECT, 1'b0, {8'h00, PSW_ADDR}, 8'h00, 16'h0010, 1, 2);
    // extended ram: off, then on, both pointer kinds and the stack
    doReq(MD_EXT_DATA_POINTER, 1'b0, 16'h0010, 8'h00, 16'h0000, 1, 4);
    doReq(MD_DIRECT, 1'b1, 16'h00AF, 8'h01, 16'h0000, 0, 2);
    checkBit(xramEnabled, 1'b1);
    doReq(MD_DIRECT, 1'b0, 16'h00AF, 8'h00, 16'h0001, 1, 2);
    doReq(MD_EXT_DATA_POINTER, 1'b1, {rnd[23:16], 8'hFF}, v, 16'h0000, 0, 4);
    doReq(MD_EXT_REG, 1'b0, 16'h00FF, 8'h00, {8'h00, v}, 1, 4);
    doReq(MD_EXT_REG, 1'b1, 16'h0000, w, 16'h0000, 0, 4);
    doReq(MD_EXT_DATA_POINTER, 1'b0, 16'h3400, 8'h00, {8'h00, w}, 1, 4);
    doReq(MD_STACK, 1'b1, 16'h0040, v, 16'h0000, 0, 4);
    doReq(MD_EXT_DATA_POINTER, 1'b0, 16'h0040, 8'h00, {8'h00, v}, 1, 4);
    // flash reads, indexed and immediate, and the indexed jump
    doReq(MD_CODE_DATA_POINTER, 1'b0, 16'h8002, v, fb(16'h8002 + 16'(v)), 1, 4);
    doReq(MD_CODE_PC, 1'b0, 16'h3FF0, w, fb(16'h3FF0 + 16'(w)), 1, 4);
    doReq(MD_JUMP, 1'b0, 16'h1200, w, 16'h1200 + 16'(w), 1, 3);
    doReq(MD_IMM_ACC, 1'b0, 16'h0123, 8'h00, fb(16'h0123), 1, 2);
    doReq(MD_IMM_DATA_POINTER, 1'b0, 16'h01FF, 8'h00, (fb(16'h01FF) << 8) | fb(16'h0200), 1, 3);
    complete_run();
  end
endmodule // mds_decoder_tb
`default_nettype wire
